// File: apgc_pkg.sv
// package for the auxiliary pin gpio and clock select block
// assumes an axi4-lite slave with 32-bit data, registers one per aligned word
package apgc_pkg;
	// register indices as printed, byte address is four times the index
	localparam logic [7:0] IDX_CTRL_PIN = 8'h64;
	localparam logic [7:0] IDX_MF_PIN = 8'h65;
	localparam logic [7:0] IDX_CLK_SEL = 8'h66;
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] ADDR_CTRL_PIN = {2'h0, IDX_CTRL_PIN, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_MF_PIN = {2'h0, IDX_MF_PIN, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_CLK_SEL = {2'h0, IDX_CLK_SEL, 2'h0};
	// field positions of the control-pin register
	localparam int DATA_MODE_HI = 7;
	localparam int DATA_MODE_LO = 6;
	localparam int DATA_OUT_BIT = 5;
	localparam int DATA_IN_BIT = 4;
	localparam int CLK_MODE_HI = 3;
	localparam int CLK_MODE_LO = 2;
	localparam int CLK_OUT_BIT = 1;
	localparam int CLK_IN_BIT = 0;
	// field positions of the multifunction-pin register
	localparam int STRAP0_BIT = 7;
	localparam int STRAP1_BIT = 6;
	localparam int MF4_IN_EN_BIT = 5;
	localparam int MF4_SDATA_EN_BIT = 4;
	localparam int MF4_IN_BIT = 3;
	localparam int MF3_OUT_EN_BIT = 2;
	localparam int MF3_OUT_BIT = 1;
	localparam int CORE_SRC_BIT = 0;
	// field positions of the clock select register
	localparam int DIV_SRC_HI = 7;
	localparam int DIV_SRC_LO = 6;
	localparam int PLL_SRC_HI = 5;
	localparam int PLL_SRC_LO = 4;
	localparam int PLL_N_HI = 3;
	localparam int PLL_N_LO = 0;
	// pin modes and clock sources
	localparam logic [1:0] MODE_NONE = 2'h0;
	localparam logic [1:0] MODE_INPUT = 2'h1;
	localparam logic [1:0] MODE_OUTPUT = 2'h2;
	localparam logic [1:0] SRC_MASTER = 2'h0;
	localparam logic [1:0] SRC_GPIO = 2'h1;
	localparam logic [1:0] SRC_BITCLK = 2'h2;
	localparam logic [1:0] CODE_RESERVED = 2'h3;
	// reset values
	localparam logic [7:0] RST_CTRL_PIN = 8'h00;
	localparam logic [7:0] RST_MF_PIN = 8'h00;
	localparam logic [3:0] RST_PLL_N = 4'h2;
	localparam logic [1:0] RST_SRC = 2'h0;
	// interface select levels
	localparam logic SEL_FOUR_WIRE = 1'b1;
	localparam logic SEL_TWO_WIRE = 1'b0;
	// pll divide values for the two wrapped codes, then the bus response codes
	localparam logic [4:0] PLL_N_CODE0 = 5'h10;
	localparam logic [4:0] PLL_N_CODE1 = 5'h11;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: apgc_top.sv
// auxiliary pin gpio, address strap status and clock source selection
// assumes pins synchronous to aclk, external pull-ups on the open-drain pins
`timescale 1ns/1ps
module apgc_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic interface_select,
	input wire logic data_pin_in,
	output logic data_pin_out,
	output logic data_pin_oe,
	input wire logic clock_pin_in,
	output logic clock_pin_out,
	output logic clock_pin_oe,
	input wire logic multifunction_pin_first,
	input wire logic multifunction_pin_second,
	output logic multifunction_pin_third,
	output logic multifunction_pin_third_oe,
	input wire logic multifunction_pin_fourth,
	output logic audio_serial_data_in,
	output logic audio_serial_data_en,
	output logic core_clock_from_plain,
	output logic [1:0] plain_divider_input_sel,
	output logic [1:0] pll_reference_input_sel,
	output logic [4:0] pll_divide_value
);
	// register storage and bus state
	logic [7:0] ctrl_cfg, next_ctrl_cfg;
	logic [7:0] mf_cfg, next_mf_cfg;
	logic [7:0] clk_cfg, next_clk_cfg;
	logic [1:0] strap, next_strap;
	logic strap_taken, next_strap_taken;
	logic aw_held, next_aw_held;
	logic w_held, next_w_held;
	logic [11:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic w_lane0, next_w_lane0;
	logic bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic rvalid, next_rvalid;
	logic [1:0] rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	// synchroniser stages for sensed pins
	logic [2:0] sync_a, sync_b;
	// pin drive registers
	logic data_oe_q, next_data_oe_q;
	logic clk_oe_q, next_clk_oe_q;
	logic mf3_q, next_mf3_q;
	logic mf3_oe_q, next_mf3_oe_q;
	logic sdata_q, next_sdata_q;
	logic sdata_en_q, next_sdata_en_q;
	logic [4:0] pll_div_q, next_pll_div_q;

	// ready outputs kept in their own flops
	logic awready_q, next_awready_q;
	logic wready_q, next_wready_q;
	logic arready_q, next_arready_q;

	// decode pll N code to divide value
	function automatic logic [4:0] apgc_pll_n(input logic [3:0] code);
		if (code == 4'h0) begin
			apgc_pll_n = apgc_pkg::PLL_N_CODE0;
		end else if (code == 4'h1) begin
			apgc_pll_n = apgc_pkg::PLL_N_CODE1;
		end else begin
			apgc_pll_n = {1'b0, code};
		end
	endfunction

	// reserved two-bit codes are refused and the old field is kept
	function automatic logic apgc_reserved(input logic [1:0] code);
		apgc_reserved = (code == apgc_pkg::CODE_RESERVED);
	endfunction

	// address match helper
	function automatic logic [1:0] apgc_decode(input logic [11:0] addr);
		if (addr == apgc_pkg::ADDR_CTRL_PIN) begin
			apgc_decode = 2'h1;
		end else if (addr == apgc_pkg::ADDR_MF_PIN) begin
			apgc_decode = 2'h2;
		end else if (addr == apgc_pkg::ADDR_CLK_SEL) begin
			apgc_decode = 2'h3;
		end else begin
			apgc_decode = 2'h0;
		end
	endfunction

	// two-stage synchroniser for the sensed pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_a <= 3'h0;
			sync_b <= 3'h0;
		end else begin
			sync_a <= {multifunction_pin_fourth, clock_pin_in, data_pin_in};
			sync_b <= sync_a;
		end
	end

	// strap capture on the first cycle after reset release
	always_comb begin
		next_strap = strap;
		next_strap_taken = 1'b1;
		if (!strap_taken) begin
			next_strap = {multifunction_pin_second, multifunction_pin_first};
		end
	end

	// write channel handling and register updates
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_lane0 = w_lane0;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_ctrl_cfg = ctrl_cfg;
		next_mf_cfg = mf_cfg;
		next_clk_cfg = clk_cfg;
		if (s_axi_awvalid && !aw_held) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_held) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_lane0 = s_axi_wstrb[0];
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (aw_held && w_held && !bvalid) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = apgc_pkg::RESP_OKAY;
			if (apgc_decode(aw_addr) == 2'h1) begin
				if (w_lane0) begin
					// reserved mode 11 is refused and keeps the old mode
					if (!apgc_reserved(w_data[apgc_pkg::DATA_MODE_HI:apgc_pkg::DATA_MODE_LO])) begin
						next_ctrl_cfg[apgc_pkg::DATA_MODE_HI:apgc_pkg::DATA_MODE_LO] =
							w_data[apgc_pkg::DATA_MODE_HI:apgc_pkg::DATA_MODE_LO];
					end
					next_ctrl_cfg[apgc_pkg::DATA_OUT_BIT] = w_data[apgc_pkg::DATA_OUT_BIT];
					if (!apgc_reserved(w_data[apgc_pkg::CLK_MODE_HI:apgc_pkg::CLK_MODE_LO])) begin
						next_ctrl_cfg[apgc_pkg::CLK_MODE_HI:apgc_pkg::CLK_MODE_LO] =
							w_data[apgc_pkg::CLK_MODE_HI:apgc_pkg::CLK_MODE_LO];
					end
					next_ctrl_cfg[apgc_pkg::CLK_OUT_BIT] = w_data[apgc_pkg::CLK_OUT_BIT];
				end
			end else if (apgc_decode(aw_addr) == 2'h2) begin
				if (w_lane0) begin
					next_mf_cfg[apgc_pkg::MF4_IN_EN_BIT] = w_data[apgc_pkg::MF4_IN_EN_BIT];
					next_mf_cfg[apgc_pkg::MF4_SDATA_EN_BIT] =
						w_data[apgc_pkg::MF4_SDATA_EN_BIT];
					next_mf_cfg[apgc_pkg::MF3_OUT_EN_BIT] = w_data[apgc_pkg::MF3_OUT_EN_BIT];
					next_mf_cfg[apgc_pkg::MF3_OUT_BIT] = w_data[apgc_pkg::MF3_OUT_BIT];
					next_mf_cfg[apgc_pkg::CORE_SRC_BIT] = w_data[apgc_pkg::CORE_SRC_BIT];
				end
			end else if (apgc_decode(aw_addr) == 2'h3) begin
				if (w_lane0) begin
					if (!apgc_reserved(w_data[apgc_pkg::DIV_SRC_HI:apgc_pkg::DIV_SRC_LO])) begin
						next_clk_cfg[apgc_pkg::DIV_SRC_HI:apgc_pkg::DIV_SRC_LO] =
							w_data[apgc_pkg::DIV_SRC_HI:apgc_pkg::DIV_SRC_LO];
					end
					if (!apgc_reserved(w_data[apgc_pkg::PLL_SRC_HI:apgc_pkg::PLL_SRC_LO])) begin
						next_clk_cfg[apgc_pkg::PLL_SRC_HI:apgc_pkg::PLL_SRC_LO] =
							w_data[apgc_pkg::PLL_SRC_HI:apgc_pkg::PLL_SRC_LO];
					end
					next_clk_cfg[apgc_pkg::PLL_N_HI:apgc_pkg::PLL_N_LO] =
						w_data[apgc_pkg::PLL_N_HI:apgc_pkg::PLL_N_LO];
				end
			end else begin
				next_bresp = apgc_pkg::RESP_SLVERR;
			end
		end
		// ready again once the held item has been used
		next_awready_q = !next_aw_held;
		next_wready_q = !next_w_held;
	end

	// read channel: one read at a time, answered one cycle after address
	always_comb begin
		next_rvalid = rvalid;
		next_rresp = rresp;
		next_rdata = rdata;
		if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && !rvalid) begin
			next_rvalid = 1'b1;
			next_rresp = apgc_pkg::RESP_OKAY;
			next_rdata = 32'h0000_0000;
			if (apgc_decode(s_axi_araddr) == 2'h1) begin
				next_rdata[7:0] = ctrl_cfg;
				if (interface_select == apgc_pkg::SEL_FOUR_WIRE) begin
					if (ctrl_cfg[apgc_pkg::DATA_MODE_HI:apgc_pkg::DATA_MODE_LO] ==
						apgc_pkg::MODE_INPUT) begin
						next_rdata[apgc_pkg::DATA_IN_BIT] = sync_b[0];
					end
					if (ctrl_cfg[apgc_pkg::CLK_MODE_HI:apgc_pkg::CLK_MODE_LO] ==
						apgc_pkg::MODE_INPUT) begin
						next_rdata[apgc_pkg::CLK_IN_BIT] = sync_b[1];
					end
				end
			end else if (apgc_decode(s_axi_araddr) == 2'h2) begin
				next_rdata[7:0] = mf_cfg;
				if (interface_select == apgc_pkg::SEL_TWO_WIRE) begin
					next_rdata[apgc_pkg::STRAP0_BIT] = strap[1];
					next_rdata[apgc_pkg::STRAP1_BIT] = strap[0];
					if (mf_cfg[apgc_pkg::MF4_IN_EN_BIT]) begin
						next_rdata[apgc_pkg::MF4_IN_BIT] = sync_b[2];
					end
				end
			end else if (apgc_decode(s_axi_araddr) == 2'h3) begin
				next_rdata[7:0] = clk_cfg;
			end else begin
				next_rresp = apgc_pkg::RESP_SLVERR;
			end
		end
		// no new read address while an answer stands
		next_arready_q = !next_rvalid;
	end

	// pin drive: control-bus pins are open drain, oe high only to pull low
	always_comb begin
		next_data_oe_q = 1'b0;
		next_clk_oe_q = 1'b0;
		next_mf3_q = 1'b0;
		next_mf3_oe_q = 1'b0;
		next_sdata_q = 1'b0;
		next_sdata_en_q = 1'b0;
		if (interface_select == apgc_pkg::SEL_FOUR_WIRE) begin
			if (ctrl_cfg[apgc_pkg::DATA_MODE_HI:apgc_pkg::DATA_MODE_LO] ==
				apgc_pkg::MODE_OUTPUT) begin
				next_data_oe_q = !ctrl_cfg[apgc_pkg::DATA_OUT_BIT];
			end
			if (ctrl_cfg[apgc_pkg::CLK_MODE_HI:apgc_pkg::CLK_MODE_LO] ==
				apgc_pkg::MODE_OUTPUT) begin
				next_clk_oe_q = !ctrl_cfg[apgc_pkg::CLK_OUT_BIT];
			end
		end
		if (interface_select == apgc_pkg::SEL_TWO_WIRE) begin
			// the third pin is push-pull, unlike the two control-bus pins
			if (mf_cfg[apgc_pkg::MF3_OUT_EN_BIT]) begin
				next_mf3_oe_q = 1'b1;
				next_mf3_q = mf_cfg[apgc_pkg::MF3_OUT_BIT];
			end
			if (mf_cfg[apgc_pkg::MF4_SDATA_EN_BIT]) begin
				next_sdata_en_q = 1'b1;
				next_sdata_q = multifunction_pin_fourth;
			end
		end
		next_pll_div_q = apgc_pll_n(clk_cfg[apgc_pkg::PLL_N_HI:apgc_pkg::PLL_N_LO]);
	end

	// register all state but the synchroniser stages
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_cfg <= apgc_pkg::RST_CTRL_PIN;
			mf_cfg <= apgc_pkg::RST_MF_PIN;
			clk_cfg <= {apgc_pkg::RST_SRC, apgc_pkg::RST_SRC, apgc_pkg::RST_PLL_N};
			strap <= 2'h0;
			strap_taken <= 1'b0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h0000_0000;
			w_lane0 <= 1'b0;
			bvalid <= 1'b0;
			bresp <= apgc_pkg::RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= apgc_pkg::RESP_OKAY;
			rdata <= 32'h0000_0000;
			data_oe_q <= 1'b0;
			clk_oe_q <= 1'b0;
			mf3_q <= 1'b0;
			mf3_oe_q <= 1'b0;
			sdata_q <= 1'b0;
			sdata_en_q <= 1'b0;
			pll_div_q <= apgc_pkg::PLL_N_CODE0;
			// ready flops leave reset high so a request may come at once
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			arready_q <= 1'b1;
		end else begin
			ctrl_cfg <= next_ctrl_cfg;
			mf_cfg <= next_mf_cfg;
			clk_cfg <= next_clk_cfg;
			strap <= next_strap;
			strap_taken <= next_strap_taken;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_lane0 <= next_w_lane0;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
			data_oe_q <= next_data_oe_q;
			clk_oe_q <= next_clk_oe_q;
			mf3_q <= next_mf3_q;
			mf3_oe_q <= next_mf3_oe_q;
			sdata_q <= next_sdata_q;
			sdata_en_q <= next_sdata_en_q;
			pll_div_q <= next_pll_div_q;
			awready_q <= next_awready_q;
			wready_q <= next_wready_q;
			arready_q <= next_arready_q;
		end
	end

	// outputs straight from flip-flops, data_pin_out and clock_pin_out tied low
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rresp = rresp;
	assign s_axi_rdata = rdata;
	assign data_pin_out = 1'b0;
	assign data_pin_oe = data_oe_q;
	assign clock_pin_out = 1'b0;
	assign clock_pin_oe = clk_oe_q;
	assign multifunction_pin_third = mf3_q;
	assign multifunction_pin_third_oe = mf3_oe_q;
	assign audio_serial_data_in = sdata_q;
	assign audio_serial_data_en = sdata_en_q;
	assign core_clock_from_plain = mf_cfg[apgc_pkg::CORE_SRC_BIT];
	assign plain_divider_input_sel = clk_cfg[apgc_pkg::DIV_SRC_HI:apgc_pkg::DIV_SRC_LO];
	assign pll_reference_input_sel = clk_cfg[apgc_pkg::PLL_SRC_HI:apgc_pkg::PLL_SRC_LO];
	assign pll_divide_value = pll_div_q;
endmodule

// File: apgc_sva.sv
// checker for the aux pin gpio and clock select block, top ports only
// assumes one aclk domain and a bind from the bench top file
`timescale 1ns/1ps
module apgc_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic interface_select,
	input wire logic data_pin_out,
	input wire logic data_pin_oe,
	input wire logic clock_pin_out,
	input wire logic clock_pin_oe,
	input wire logic multifunction_pin_third_oe,
	input wire logic [4:0] pll_divide_value
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// open-drain pins never drive a high level
	a_data_od_low: assert property (
		data_pin_out == 1'b0) else $error("data pin drives high");
	a_clock_od_low: assert property (
		clock_pin_out == 1'b0) else $error("clock pin drives high");
	// control-pin pulls only in four-wire mode, one cycle of lag allowed
	a_data_oe_mode: assert property (
		data_pin_oe |-> interface_select || $past(interface_select))
		else $error("data pin pulled in two-wire mode");
	a_clock_oe_mode: assert property (
		clock_pin_oe |-> interface_select || $past(interface_select))
		else $error("clock pin pulled in two-wire mode");
	// third pin drives only in two-wire mode
	a_third_oe_mode: assert property (
		multifunction_pin_third_oe |-> !interface_select || !$past(interface_select))
		else $error("third pin driven in four-wire mode");
	// divide value always within the mapped span
	a_pll_n_range: assert property (
		pll_divide_value >= 5'h02 && pll_divide_value <= 5'h11)
		else $error("pll divide value out of range");
	// bus answers hold until taken
	a_bresp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rdata_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_rdata_upper: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper read bits set");
endmodule

// File: apgc_pins.sv
// pin environment: pull-ups and external pull-downs on the two control-bus pins
// assumes the block pulls a pin low only while its enable is high
`timescale 1ns/1ps
module apgc_pins (
	input wire logic data_oe,
	input wire logic data_out,
	input wire logic clock_oe,
	input wire logic clock_out,
	input wire logic ext_data_low,
	input wire logic ext_clock_low,
	output logic data_level,
	output logic clock_level
);
	// wired-and of both parties, pull-up when both release
	assign data_level = (data_oe ? data_out : 1'b1) & ~ext_data_low;
	assign clock_level = (clock_oe ? clock_out : 1'b1) & ~ext_clock_low;
endmodule

// File: aux_pin_gpio_and_clock_select_tb.sv
// self-checking bench: axi4-lite master, pin environment, queue of expected answers
// assumes apgc_pkg, apgc_top, apgc_pins and apgc_sva compiled before this file
`timescale 1ns/1ps
module aux_pin_gpio_and_clock_select_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic sel = 1'b0, mf1 = 1'b1, mf2 = 1'b0, mf4 = 1'b0, xd = 1'b0, xc = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, doe, dout, coe, cout, m3, m3oe;
	logic asd, asden, cfp, dlev, clev;
	logic [1:0] bresp, rresp, pds, prs, dm, cm, ds, ps;
	logic [4:0] pdv;
	logic [7:0] v;
	logic [31:0] rdata, rnd, x;
	logic [33:0] e;
	logic [33:0] q[$];
	int fails = 0;
	int checks = 0;

	apgc_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .interface_select(sel), .data_pin_in(dlev), .data_pin_out(dout),
		.data_pin_oe(doe), .clock_pin_in(clev), .clock_pin_out(cout), .clock_pin_oe(coe),
		.multifunction_pin_first(mf1), .multifunction_pin_second(mf2),
		.multifunction_pin_third(m3), .multifunction_pin_third_oe(m3oe),
		.multifunction_pin_fourth(mf4), .audio_serial_data_in(asd), .audio_serial_data_en(asden),
		.core_clock_from_plain(cfp), .plain_divider_input_sel(pds),
		.pll_reference_input_sel(prs), .pll_divide_value(pdv));
	apgc_pins pins_u (.data_oe(doe), .data_out(dout), .clock_oe(coe), .clock_out(cout),
		.ext_data_low(xd), .ext_clock_low(xc), .data_level(dlev), .clock_level(clev));

	// 125 MHz clock
	always #4 aclk = ~aclk;

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// one write, answer taken one edge after it shows
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
		q.push_back({r, 32'h00000000});
		awaddr <= a;
		wdata <= {rnd[31:8], d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b1;
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		q.push_back({r, d});
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b1;
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	// monitor: compare each bus answer with the oldest note
	always @(posedge aclk) begin
		if ((bvalid && bready) || (rvalid && rready)) begin
			e = q.pop_front();
			chk(32'((rvalid && rready) ? rresp : bresp), 32'(e[33:32]));
			if (rvalid && rready) chk(rdata, e[31:0]);
		end
	end

	task automatic test_done;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// watchdog
	initial begin
		#200000;
		fails++;
		$display("BAD %0t watchdog expired", $time);
		test_done();
	end

	// main sequence
	initial begin
		rnd = 32'hB9F1C5BD;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		cyc(3);
		mf1 <= 1'b0;
		mf2 <= 1'b1;
		chk(32'(pdv), 32'h00000002);
		rd(apgc_pkg::ADDR_CTRL_PIN, 32'h00000000, apgc_pkg::RESP_OKAY);
		rd(apgc_pkg::ADDR_MF_PIN, 32'h00000040, apgc_pkg::RESP_OKAY);
		rd(apgc_pkg::ADDR_CLK_SEL, 32'h00000002, apgc_pkg::RESP_OKAY);
		rd(12'h1A0, 32'h00000000, apgc_pkg::RESP_SLVERR);
		wr(12'h1A0, 8'hFF, apgc_pkg::RESP_SLVERR);
		mf4 <= 1'b1;
		wr(apgc_pkg::ADDR_MF_PIN, 8'hFF, apgc_pkg::RESP_OKAY);
		wr(apgc_pkg::ADDR_CTRL_PIN, 8'h80, apgc_pkg::RESP_OKAY);
		cyc(4);
		rd(apgc_pkg::ADDR_MF_PIN, 32'h0000007F, apgc_pkg::RESP_OKAY);
		chk({28'h0000000, m3oe, m3, asden, asd}, 32'h0000000F);
		chk({30'h00000000, cfp, doe}, 32'h00000002);
		mf4 <= 1'b0;
		wr(apgc_pkg::ADDR_MF_PIN, 8'h24, apgc_pkg::RESP_OKAY);
		cyc(4);
		rd(apgc_pkg::ADDR_MF_PIN, 32'h00000064, apgc_pkg::RESP_OKAY);
		chk({28'h0000000, m3oe, m3, asden, cfp}, 32'h00000008);
		sel <= 1'b1;
		mf4 <= 1'b1;
		cyc(4);
		rd(apgc_pkg::ADDR_MF_PIN, 32'h00000024, apgc_pkg::RESP_OKAY);
		chk({29'h00000000, m3oe, doe, dlev}, 32'h00000002);
		dm = apgc_pkg::MODE_OUTPUT;
		cm = apgc_pkg::MODE_NONE;
		ds = apgc_pkg::SRC_MASTER;
		ps = apgc_pkg::SRC_MASTER;
		// every pin mode code, random levels and outputs
		for (int i = 0; i < 16; i++) begin
			rnd = nxt(rnd);
			v = {i[1:0], rnd[5:4], i[3:2], rnd[1:0]};
			xd <= rnd[8];
			xc <= rnd[9];
			dm = (v[7:6] == 2'h3) ? dm : v[7:6];
			cm = (v[3:2] == 2'h3) ? cm : v[3:2];
			wr(apgc_pkg::ADDR_CTRL_PIN, v, apgc_pkg::RESP_OKAY);
			cyc(4);
			x = {24'h000000, dm, v[5], dm == apgc_pkg::MODE_INPUT && !rnd[8], cm, v[1], 1'b0};
			x[0] = cm == apgc_pkg::MODE_INPUT && !rnd[9];
			rd(apgc_pkg::ADDR_CTRL_PIN, x, apgc_pkg::RESP_OKAY);
			x = {30'h00000000, dm == apgc_pkg::MODE_OUTPUT && !v[5], cm == apgc_pkg::MODE_OUTPUT && !v[1]};
			chk({30'h00000000, doe, coe}, x);
			chk({30'h00000000, dlev, clev}, {30'h00000000, ~x[1] & ~rnd[8], ~x[0] & ~rnd[9]});
		end
		// every divider code, random source fields
		for (int i = 0; i < 16; i++) begin
			rnd = nxt(rnd);
			v = {rnd[7:4], 4'(i)};
			ds = (v[7:6] == 2'h3) ? ds : v[7:6];
			ps = (v[5:4] == 2'h3) ? ps : v[5:4];
			wr(apgc_pkg::ADDR_CLK_SEL, v, apgc_pkg::RESP_OKAY);
			cyc(4);
			rd(apgc_pkg::ADDR_CLK_SEL, {24'h000000, ds, ps, v[3:0]}, apgc_pkg::RESP_OKAY);
			chk({28'h0000000, pds, prs}, {28'h0000000, ds, ps});
			chk(32'(pdv), (i < 2) ? 32'(i + 16) : 32'(i));
		end
		test_done();
	end
endmodule

bind apgc_top apgc_sva sva_u (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .interface_select(interface_select),
	.data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe), .clock_pin_out(clock_pin_out),
	.clock_pin_oe(clock_pin_oe), .multifunction_pin_third_oe(multifunction_pin_third_oe),
	.pll_divide_value(pll_divide_value));
